// [sbp_pin_function.v]
`include "sbp_defs.vh"

////////////////////////////////////////////////////////////////////////////////
module sbp_pin_function #(
    parameter PLL_MULT = 1012
) (
    // clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire        sw_reset_active_i,
    // reference clock
    input  wire        ref_clk_i,
    output reg         system_clock_en_o,
    // bus cycle from core
    input  wire        cyc_valid_i,
    input  wire        cyc_read_i,
    input  wire        cyc_dram_i,
    input  wire        cyc_refresh_i,
    input  wire        cyc_secondary_i,
    input  wire        cyc_ext_ack_i,
    input  wire        cyc_width16_i,
    input  wire [1:0]  cyc_byte_en_i,
    input  wire [23:0] cyc_addr_i,
    input  wire [15:0] cyc_dram_mux_address_i,
    input  wire        sleep_i,
    // configuration
    input  wire        static_ram_sixteen_mode_i,
    input  wire        dram_control_reg_en_i,
    input  wire        port_e_bit3_sel_i,
    input  wire        port_g_bit0_sel_i,
    input  wire        port_g_bit0_dir_i,
    input  wire        port_g_bit0_out_i,
    input  wire        a0_sel_we_i,
    input  wire        a0_sel_i,
    input  wire        ahi_sel_we_i,
    input  wire [3:0]  ahi_sel_i,
    input  wire        clock_out_we_i,
    input  wire        clock_out_sel_i,
    input  wire        pll_clock_out_en_i,
    input  wire        clock_generator_i,
    input  wire        narrow_bus_select_i,
    // pins in
    input  wire        bus_width_strap_i,
    input  wire [7:0]  port_d_pin_i,
    input  wire [7:0]  port_d_edge_mode_i,
    input  wire [7:0]  port_d_irq_en_i,
    input  wire        irq_level5_pin_i,
    input  wire        irq_level5_en_i,
    input  wire        irq_level5_high_i,
    input  wire        debug_irq_pin_n_i,
    input  wire [1:0]  debug_brk_i,
    input  wire        debug_status_wr_i,
    input  wire [2:0]  debug_status_wdata_i,
    input  wire        uart_ext_clock_i,
    // outputs
    output reg         boot_width16_o,
    output reg         transfer_ack_o,
    output reg         ack_pin_oe_o,
    output reg         ack_pin_out_o,
    output reg         lower_write_strobe_n_o,
    output reg         upper_write_strobe_n_o,
    output reg         byte_strobe_mode_o,
    output reg         dram_write_strobe_n_o,
    output reg         port_e_bit3_oe_o,
    output reg         uart_ext_clock_o,
    output reg         output_enable_n_o,
    output reg  [23:0] addr_o,
    output reg         a0_is_addr_o,
    output reg  [3:0]  ahi_is_addr_o,
    output reg         data_pullup_o,
    output reg         port_a_gpio_ok_o,
    output reg         clock_out_pin_o,
    output reg         clock_out_oe_o,
    output reg  [7:0]  port_d_irq_o,
    output reg  [7:0]  port_d_pullup_o,
    output reg         irq_level5_o,
    output reg  [2:0]  debug_status_reg_o,
    output reg         debug_irq_flag_o
);

////////////////////////////////////////////////////////////////////////////////
// synchronisers for pins; reset to the idle-high level so that the
// edge detectors behind them see no false edge after reset
reg  [11:0] sync1_q;
reg  [11:0] sync2_q;
wire [11:0] pins_raw = {port_d_pin_i, irq_level5_pin_i,
                        debug_irq_pin_n_i, uart_ext_clock_i, ref_clk_i};

always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        sync1_q <= 12'hFFF;
        sync2_q <= 12'hFFF;
    end else begin
        sync1_q <= pins_raw;
        sync2_q <= sync1_q;
    end
end

////////////////////////////////////////////////////////////////////////////////
// strap synchroniser has no reset: the strap must be followed while reset
// is still low, so the level at the release edge is ready at the first edge
reg         strap_sync1_q;
reg         strap_sync2_q;

always @(posedge clk_sys_i) begin
    strap_sync1_q <= bus_width_strap_i;
    strap_sync2_q <= strap_sync1_q;
end

wire       strap_s   = strap_sync2_q;
wire [7:0] port_d_s  = sync2_q[11:4];
wire       irq_level5_pin_s    = sync2_q[3];
wire       dbg_n_s   = sync2_q[2];
wire       uart_ext_clock_s    = sync2_q[1];
wire       ref_s     = sync2_q[0];

////////////////////////////////////////////////////////////////////////////////
// reset-release tracking; sw_rst_q is cleared with rst_seen_q, so software reset never masks the strap capture
reg        rst_seen_q;
reg        sw_rst_q;

always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        rst_seen_q <= 1'h0;
        sw_rst_q   <= 1'h0;
    end else begin
        rst_seen_q <= 1'h1;
        sw_rst_q   <= sw_reset_active_i;
    end
end

// strap caught at the first edge after release, not under async reset
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        boot_width16_o <= `SBP_WIDTH_8;
    end else if (!rst_seen_q && !sw_rst_q) begin
        boot_width16_o <= strap_s ? `SBP_WIDTH_16 : `SBP_WIDTH_8;
    end
end

////////////////////////////////////////////////////////////////////////////////
// system clock enable: reference edge counting approximates the pll ratio
reg        ref_d_q;
reg [10:0] pll_cnt_q;

always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        ref_d_q           <= 1'h1;
        pll_cnt_q         <= 11'h000;
        system_clock_en_o <= 1'h0;
    end else begin
        ref_d_q <= ref_s;
        // a faster clock is not made here: one enable per reference edge
        // times multiplier limited by the 50 MHz host clock
        if (ref_s && !ref_d_q) begin
            pll_cnt_q <= PLL_MULT[10:0];
        end else if (pll_cnt_q != 11'h000) begin
            pll_cnt_q <= pll_cnt_q - 11'h001;
        end
        system_clock_en_o <= (pll_cnt_q != 11'h000);
    end
end

////////////////////////////////////////////////////////////////////////////////
// pin function selects
always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        a0_is_addr_o  <= `SBP_A0_SEL_RST;
        ahi_is_addr_o <= `SBP_AHI_SEL_RST;
        clock_out_oe_o <= `SBP_CLOCK_OUT_PIN_SEL_RST;
    end else begin
        if (a0_sel_we_i) begin
            a0_is_addr_o <= a0_sel_i;
        end
        if (ahi_sel_we_i) begin
            ahi_is_addr_o <= ahi_sel_i;
        end
        if (clock_out_we_i) begin
            clock_out_oe_o <= clock_out_sel_i;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// bus strobes, address and acknowledge
wire dram_we_sel = port_e_bit3_sel_i && dram_control_reg_en_i;
wire write_cyc   = cyc_valid_i && !cyc_read_i;
wire byte_cyc    = cyc_valid_i && cyc_secondary_i && static_ram_sixteen_mode_i;

// external acknowledge counts only while the pin is still the ack input
wire ack_pin_free = !port_g_bit0_sel_i;
wire ext_ack_seen = ack_pin_free && !strap_s;

// address next value; sleep keeps the last cycle's address on the pins
wire        addr_load = cyc_valid_i && !sleep_i;
wire [23:0] addr_d    = cyc_dram_i ?
                        {cyc_addr_i[23:17], cyc_dram_mux_address_i, cyc_addr_i[0]} :
                        cyc_addr_i;

////////////////////////////////////////////////////////////////////////////////
// strobe next values
reg lower_strobe_n_d;
reg upper_strobe_n_d;
reg byte_mode_d;

always @* begin
    lower_strobe_n_d = 1'h1;
    upper_strobe_n_d = 1'h1;
    byte_mode_d      = 1'h0;
    if (byte_cyc) begin
        // byte strobes qualify reads as well as writes
        byte_mode_d      = 1'h1;
        lower_strobe_n_d = !cyc_byte_en_i[0];
        upper_strobe_n_d = !cyc_byte_en_i[1];
    end else if (cyc_width16_i) begin
        lower_strobe_n_d = !(write_cyc && cyc_byte_en_i[0]);
        upper_strobe_n_d = !(write_cyc && cyc_byte_en_i[1]);
    end else begin
        // narrow port: only the upper strobe ever moves
        upper_strobe_n_d = !write_cyc;
    end
end

////////////////////////////////////////////////////////////////////////////////
// registered pin outputs

always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        transfer_ack_o         <= 1'h0;
        ack_pin_oe_o           <= 1'h0;
        ack_pin_out_o          <= 1'h0;
        lower_write_strobe_n_o <= 1'h1;
        upper_write_strobe_n_o <= 1'h1;
        byte_strobe_mode_o     <= 1'h0;
        dram_write_strobe_n_o  <= 1'h1;
        port_e_bit3_oe_o       <= 1'h0;
        uart_ext_clock_o       <= 1'h0;
        output_enable_n_o      <= 1'h1;
        addr_o                 <= 24'h000000;
        data_pullup_o          <= 1'h0;
        port_a_gpio_ok_o       <= 1'h0;
        clock_out_pin_o        <= 1'h0;
    end else begin
        // pin stays acknowledge unless port g takes it as output/gpio
        ack_pin_oe_o  <= port_g_bit0_sel_i && port_g_bit0_dir_i;
        ack_pin_out_o <= port_g_bit0_out_i;
        transfer_ack_o <= cyc_valid_i && (!cyc_ext_ack_i || ext_ack_seen);
        byte_strobe_mode_o     <= byte_mode_d;
        lower_write_strobe_n_o <= lower_strobe_n_d;
        upper_write_strobe_n_o <= upper_strobe_n_d;
        dram_write_strobe_n_o <= !(dram_we_sel && write_cyc && cyc_dram_i &&
                                   !cyc_refresh_i);
        port_e_bit3_oe_o <= dram_we_sel;
        uart_ext_clock_o <= dram_we_sel ? 1'h0 : uart_ext_clock_s;
        output_enable_n_o <= !(cyc_valid_i && cyc_read_i);
        // sleep freezes the address at the last cycle's value
        if (addr_load) begin
            addr_o <= addr_d;
        end
        data_pullup_o    <= sleep_i;
        port_a_gpio_ok_o <= narrow_bus_select_i;
        clock_out_pin_o  <= clock_out_oe_o && pll_clock_out_en_i &&
                            clock_generator_i;
    end
end

////////////////////////////////////////////////////////////////////////////////
// interrupt pins
reg [7:0] port_d_d_q;
reg       dbg_d_q;

// edge mode: falling edge; level mode: low level
wire [7:0] port_d_fell  = port_d_d_q & ~port_d_s;
wire [7:0] port_d_irq_d = port_d_irq_en_i &
                          ((port_d_edge_mode_i & port_d_fell) |
                           (~port_d_edge_mode_i & ~port_d_s));

// set wins over a simultaneous write-one clear, so no event is lost
wire [2:0] dbg_clr_mask   = debug_status_wr_i ? debug_status_wdata_i : 3'h0;
wire       dbg_pin_fell   = dbg_d_q && !dbg_n_s;
wire [2:0] dbg_set        = {dbg_pin_fell, debug_brk_i};
wire [2:0] debug_status_d = (debug_status_reg_o & ~dbg_clr_mask) | dbg_set;

always @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
        port_d_d_q         <= 8'hFF;
        dbg_d_q            <= 1'h1;
        port_d_irq_o       <= 8'h00;
        port_d_pullup_o    <= 8'hFF;
        irq_level5_o       <= 1'h0;
        debug_status_reg_o <= 3'h0;
        debug_irq_flag_o   <= 1'h0;
    end else begin
        port_d_d_q <= port_d_s;
        dbg_d_q    <= dbg_n_s;
        port_d_irq_o <= port_d_irq_d;
        port_d_pullup_o <= ~port_d_irq_en_i;
        irq_level5_o <= irq_level5_en_i &&
                        (irq_level5_pin_s == irq_level5_high_i);
        debug_status_reg_o <= debug_status_d;
        debug_irq_flag_o   <= |debug_status_d;
    end
end

endmodule // sbp_pin_function

// [sbp_defs.vh]
`ifndef SBP_DEFS_VH
`define SBP_DEFS_VH
// clock generation figures
`define SBP_REF_CLK_HZ      32768
`define SBP_SYS_CLK_HZ      16580000
`define SBP_PLL_MULT        1012
`define SBP_PRE1_DIV        2'h1
`define SBP_PRE2_DIV        2'h1
// boot port width encoding
`define SBP_WIDTH_8         1'h0
`define SBP_WIDTH_16        1'h1
// port select reset values: 1 = dedicated function
`define SBP_A0_SEL_RST      1'h1
`define SBP_AHI_SEL_RST     4'hF
`define SBP_CLOCK_OUT_PIN_SEL_RST    1'h0
`define SBP_PE3_SEL_RST     1'h0
// debug status bit positions
`define SBP_DBG_BRK0        0
`define SBP_DBG_BRK1        1
`define SBP_DBG_PIN         2
`define SBP_DBG_W           3
`endif

// [sbp_pin_function_props.sv]
module sbp_pin_function_props (
    // clock, reset, cycle, configuration and debug inputs
    input wire       clk_sys_i, rst_n_i, cyc_valid_i, cyc_read_i, cyc_refresh_i,
    input wire       cyc_secondary_i, cyc_ext_ack_i, cyc_width16_i, sleep_i,
    input wire       static_ram_sixteen_mode_i, dram_control_reg_en_i, port_e_bit3_sel_i,
    input wire       debug_irq_pin_n_i, debug_status_wr_i,
    input wire [2:0] debug_status_wdata_i,
    // watched outputs
    input wire       output_enable_n_o, transfer_ack_o, lower_write_strobe_n_o,
    input wire       byte_strobe_mode_o, dram_write_strobe_n_o, port_e_bit3_oe_o,
    input wire       data_pullup_o,
    input wire [23:0] addr_o,
    input wire [2:0] debug_status_reg_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_narrow_wr;
        cyc_valid_i && !cyc_read_i && !cyc_secondary_i && !cyc_width16_i;
    endsequence
    // pin quiet long enough that no new edge can set bit 2 behind the clear
    sequence s_quiet_clr;
        debug_irq_pin_n_i [*5] ##0 (debug_status_wr_i && debug_status_wdata_i[2]);
    endsequence
    a_read_oe_low: assert property (cyc_valid_i && cyc_read_i |=> !output_enable_n_o)
        else $error("read without output enable");
    a_refresh_dram_idle: assert property (cyc_valid_i && cyc_refresh_i |=> dram_write_strobe_n_o)
        else $error("dram strobe low in refresh");
    a_sleep_addr_hold: assert property (sleep_i |=> $stable(addr_o))
        else $error("address moved in sleep");
    a_sleep_pull_up: assert property (sleep_i |=> data_pullup_o)
        else $error("no data pull-up in sleep");
    a_internal_ack: assert property (cyc_valid_i && !cyc_ext_ack_i |=> transfer_ack_o)
        else $error("internal ack missing");
    a_narrow_lower_off: assert property (s_narrow_wr |=> lower_write_strobe_n_o)
        else $error("lower strobe on narrow port");
    a_sec_byte_mode: assert property (cyc_valid_i && cyc_secondary_i && static_ram_sixteen_mode_i
        |=> byte_strobe_mode_o)
        else $error("byte strobe mode missing");
    a_uart_keeps_pin: assert property (!(port_e_bit3_sel_i && dram_control_reg_en_i)
        |=> !port_e_bit3_oe_o)
        else $error("dram strobe driven while off");
    a_dbg_pin_sets: assert property ($fell(debug_irq_pin_n_i) |-> ##[1:4] debug_status_reg_o[2])
        else $error("debug pin edge not flagged");
    a_dbg_clear_bit: assert property (s_quiet_clr |=> !debug_status_reg_o[2])
        else $error("debug bit not cleared");
endmodule // sbp_pin_function_props

// [sbp_bus_model.sv]
module sbp_bus_model (
    // clock and reset
    input  wire  clk_sys_i,
    input  wire  rst_n_i,
    // strap level and acknowledge request
    input  wire  strap_lvl_i,
    input  wire  ack_req_i,
    // shared strap and acknowledge pin
    output logic bus_width_strap_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold_q;
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) hold_q <= 2'h0;
        else if (hold_q != 2'h3) hold_q <= hold_q + 2'h1;
    end
    // strap held past release, then the pull-up wins unless acknowledging
    assign bus_width_strap_o = (!rst_n_i || hold_q != 2'h3) ? strap_lvl_i : !ack_req_i;
endmodule // sbp_bus_model

// [sbp_pin_function_test.sv]
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
    $display("Error at %0t: got %h expected %h", $time, a, e); end end
module sbp_pin_function_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 0, rst_n_i = 0, sw_reset_active_i = 0, ref_clk_i = 0, cyc_valid_i = 0;
    logic cyc_read_i = 0, cyc_dram_i = 0, cyc_refresh_i = 0, cyc_secondary_i = 0;
    logic cyc_ext_ack_i = 0, cyc_width16_i = 0, sleep_i = 0, static_ram_sixteen_mode_i = 0;
    logic dram_control_reg_en_i = 0, port_e_bit3_sel_i = 0, port_g_bit0_sel_i = 0;
    logic port_g_bit0_dir_i = 0, port_g_bit0_out_i = 0, a0_sel_we_i = 0, a0_sel_i = 0;
    logic ahi_sel_we_i = 0, clock_out_we_i = 0, clock_out_sel_i = 0, pll_clock_out_en_i = 0;
    logic clock_generator_i = 0, narrow_bus_select_i = 0, irq_level5_pin_i = 0;
    logic irq_level5_en_i = 0, irq_level5_high_i = 0, debug_irq_pin_n_i = 1;
    logic debug_status_wr_i = 0, uart_ext_clock_i = 0, strap_lvl = 0, ack_req = 0;
    logic [1:0] cyc_byte_en_i = 0, debug_brk_i = 0;
    logic [2:0] debug_status_wdata_i = 0;
    logic [3:0] ahi_sel_i = 0;
    logic [7:0] port_d_pin_i = 0, port_d_edge_mode_i = 0, port_d_irq_en_i = 0;
    logic [15:0] cyc_dram_mux_address_i = 0;
    logic [23:0] cyc_addr_i = 0;
    wire bus_width_strap_i, system_clock_en_o, boot_width16_o, transfer_ack_o, ack_pin_oe_o;
    wire ack_pin_out_o, lower_write_strobe_n_o, upper_write_strobe_n_o, byte_strobe_mode_o;
    wire dram_write_strobe_n_o, port_e_bit3_oe_o, uart_ext_clock_o, output_enable_n_o;
    wire a0_is_addr_o, data_pullup_o, port_a_gpio_ok_o, clock_out_pin_o, clock_out_oe_o;
    wire irq_level5_o, debug_irq_flag_o;
    wire [2:0] debug_status_reg_o;
    wire [3:0] ahi_is_addr_o;
    wire [7:0] port_d_irq_o, port_d_pullup_o;
    wire [23:0] addr_o;
    int n_fail = 0, checked = 0;
    logic [63:0] v;
    logic [31:0] w;
    logic [1:0] e2;
    sbp_pin_function #(.PLL_MULT(4)) DUT (.*);
    sbp_bus_model u_bus (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .strap_lvl_i(strap_lvl),
        .ack_req_i(ack_req), .bus_width_strap_o(bus_width_strap_i));
    initial forever #10 clk_sys_i = ~clk_sys_i;
    function automatic logic [23:0] f_addr(logic d, logic [23:0] a, logic [15:0] m);
        return d ? {a[23:17], m, a[0]} : a;
    endfunction
    task automatic finish_test;
        if (n_fail == 0 && checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        strap_lvl <= s;
        repeat (6) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        #1 `CHK(boot_width16_o, s)
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    initial begin
        void'($urandom(4153));
        do_reset(1'b0);
        `CHK({a0_is_addr_o, ahi_is_addr_o}, 5'h1F)
        `CHK({clock_out_oe_o, port_d_pullup_o}, 9'h0FF)
        do_reset(1'b1);
        for (int i = 0; i < 60; i++) begin
            @(posedge clk_sys_i);
            v = {$urandom, $urandom};
            w = $urandom;
            if (i < 3) v[3:0] = 4'h0;  // narrow writes first
            cyc_valid_i <= 1'b1;
            {cyc_width16_i, cyc_secondary_i, cyc_dram_i, cyc_read_i} <= v[3:0];
            {cyc_byte_en_i, cyc_addr_i, cyc_dram_mux_address_i} <= v[45:4];
            {clock_out_sel_i, clock_out_we_i, a0_sel_i, a0_sel_we_i, port_d_pin_i,
             pll_clock_out_en_i, narrow_bus_select_i, ref_clk_i, uart_ext_clock_i,
             irq_level5_pin_i, static_ram_sixteen_mode_i} <= v[63:46];
            {ahi_sel_we_i, ahi_sel_i, port_d_edge_mode_i, port_d_irq_en_i} <= w[20:0];
            step(1);
            `CHK(output_enable_n_o, !v[0])
            `CHK(addr_o, f_addr(v[1], v[43:20], v[19:4]))
            `CHK(transfer_ack_o, 1'b1)
            `CHK({byte_strobe_mode_o, port_a_gpio_ok_o}, {v[2] & v[46], v[50]})
            if (v[60]) `CHK(a0_is_addr_o, v[61])
            if (w[20]) `CHK(ahi_is_addr_o, w[19:16])
            if (v[62]) `CHK(clock_out_oe_o, v[63])
            e2 = v[3] ? {!v[44], !v[45]} : 2'h2;
            if (!v[0] && !v[2]) `CHK({lower_write_strobe_n_o, upper_write_strobe_n_o}, e2)
        end
        @(posedge clk_sys_i);
        {cyc_refresh_i, cyc_ext_ack_i, cyc_read_i} <= 3'h6;
        step(4);
        `CHK({dram_write_strobe_n_o, transfer_ack_o}, 2'h2)
        @(posedge clk_sys_i);
        {cyc_refresh_i, ack_req} <= 2'h1;
        step(4);
        `CHK(transfer_ack_o, 1'b1)
        @(posedge clk_sys_i);
        {cyc_dram_i, cyc_ext_ack_i, ack_req} <= 3'h0;
        cyc_addr_i <= 24'h5A5A5A;
        @(posedge clk_sys_i);
        {cyc_valid_i, sleep_i} <= 2'h3;
        cyc_addr_i <= 24'hA5A5A5;
        step(3);
        `CHK({addr_o, data_pullup_o}, 25'h0B4B4B5)
        @(posedge clk_sys_i);
        {sleep_i, port_e_bit3_sel_i, dram_control_reg_en_i} <= 3'h3;
        step(3);
        `CHK({port_e_bit3_oe_o, uart_ext_clock_o}, 2'h2)
        @(posedge clk_sys_i);
        {port_d_edge_mode_i, port_d_irq_en_i, port_d_pin_i, ref_clk_i} <= {24'h00FF0F, 1'b0};
        step(6);
        `CHK({port_d_irq_o, port_d_pullup_o}, 16'hF000)
        @(posedge clk_sys_i);
        ref_clk_i <= 1'b1;
        step(4);
        `CHK(system_clock_en_o, 1'b1)
        step(4);
        `CHK(system_clock_en_o, 1'b0)
        for (int p = 0; p < 2; p++) begin
            @(posedge clk_sys_i);
            {irq_level5_en_i, irq_level5_high_i, irq_level5_pin_i} <= {1'b1, p[0], p[0]};
            step(5);
            `CHK(irq_level5_o, 1'b1)
        end
        @(posedge clk_sys_i);
        {debug_irq_pin_n_i, debug_brk_i} <= 3'h3;
        @(posedge clk_sys_i);
        {debug_irq_pin_n_i, debug_brk_i} <= 3'h4;
        step(5);
        `CHK({debug_status_reg_o, debug_irq_flag_o}, 4'hF)
        @(posedge clk_sys_i);
        {debug_status_wr_i, debug_status_wdata_i} <= 4'hC;
        @(posedge clk_sys_i);
        debug_status_wr_i <= 1'b0;
        step(1);
        `CHK(debug_status_reg_o, 3'h3)
        finish_test;
    end
    initial begin
        #100us;
        n_fail++;
        finish_test;
    end
endmodule // sbp_pin_function_test
bind sbp_pin_function sbp_pin_function_props u_props (.*);
